// *** verilog/dswl_loader.sv ***
/*
  dswl_loader: serial word loader of a 10-bit voltage-output converter.
  Holds the converter code and power mode on the system clock; words
  arrive over a three-wire link clocked by the host.
  Assumes: serial clock idles outside frames; at least three system
  clocks pass between two completed words.
*/
`timescale 1ns/1ns

// Functional notes
// - shift register disabled while frame sync high, enabled once it falls.
// - the first 16 falling serial clock edges of a frame each shift one data bit into 16 bits.
// - the sixteenth falling edge transfers the word and updates the output.
// - frame sync rising before edge sixteen aborts; converter keeps old code.
// - after power-up the output is zero until a full valid write.
// - a ten-bit unsigned code from each accepted word sets the level.
// - a serially selected power-down mode forces the output off.
module dswl_loader (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // serial link
  input wire logic sclk_i,
  input wire logic frame_n_i,
  input wire logic din_i,
  // converter side
  output logic [dswl_pkg::CODE_BITS-1:0] analog_level_out_o,
  output logic [1:0] power_mode_o,
  // status
  output logic powered_down_o,
  output logic loaded_o,
  output logic frame_active_o,
  output logic update_o,
  output logic abort_o
);

  typedef enum logic [1:0] {
    DSWL_PH_RESET = 2'b00,
    DSWL_PH_IDLE = 2'b01,
    DSWL_PH_FRAME = 2'b10
  } dswl_phase_t;

  typedef struct packed {
    dswl_phase_t phase;
    logic tgl_prev;
    logic word_seen;
    logic [dswl_pkg::CODE_BITS-1:0] code;
    dswl_pkg::dswl_mode_t mode;
    logic [dswl_pkg::CODE_BITS-1:0] level;
    dswl_pkg::dswl_status_t status;
  } dswl_state_t;

  dswl_state_t st;
  dswl_state_t next_st;

  dswl_pkg::dswl_link_t link;
  logic [dswl_pkg::WORD_BITS-1:0] link_word;
  logic link_tgl;
  logic [1:0] synced;
  logic tgl_sync;
  logic frame_n_sync;
  logic word_edge;

  assign link.frame_n = frame_n_i;
  assign link.din = din_i;

  // link-domain capture
  dswl_link_shift u_link (
    .sclk_i(sclk_i),
    .link_i(link),
    .resetn_i(resetn_i),
    .word_o(link_word),
    .toggle_o(link_tgl)
  );

  // toggle and frame level into the system domain
  // frame sync resets to its idle high level: no false frame or abort
  dswl_sync2 #(
    .WIDTH(2),
    .RESET_VAL(2'b01)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i({link_tgl, frame_n_i}),
    .sync_o(synced)
  );

  assign tgl_sync = synced[1];
  assign frame_n_sync = synced[0];
  assign word_edge = tgl_sync ^ st.tgl_prev;

  always_comb begin
    next_st = st;
    next_st.tgl_prev = tgl_sync;
    next_st.status.update = 1'b0;
    next_st.status.abort = 1'b0;
    next_st.status.frame_active = ~frame_n_sync;
    // held word is stable here: no new word before the toggle settles
    if (word_edge) begin
      next_st.code = link_word[dswl_pkg::CODE_MSB:dswl_pkg::CODE_LSB];
      next_st.mode = dswl_pkg::dswl_mode_t'(
        link_word[dswl_pkg::MODE_MSB:dswl_pkg::MODE_LSB]);
      next_st.status.update = 1'b1;
      next_st.status.loaded = 1'b1;
    end
    case (st.phase)
      DSWL_PH_RESET: begin
        next_st.phase = DSWL_PH_IDLE;
      end
      DSWL_PH_IDLE: begin
        next_st.word_seen = word_edge;
        if (!frame_n_sync) begin
          next_st.phase = DSWL_PH_FRAME;
        end
      end
      DSWL_PH_FRAME: begin
        if (word_edge) begin
          next_st.word_seen = 1'b1;
        end
        if (frame_n_sync) begin
          next_st.phase = DSWL_PH_IDLE;
          // frame closed without a full word
          next_st.status.abort = ~(st.word_seen | word_edge);
          next_st.word_seen = 1'b0;
        end
      end
      default: begin
        next_st.phase = DSWL_PH_IDLE;
      end
    endcase
    next_st.status.powered_down = (next_st.mode != dswl_pkg::DSWL_MODE_RUN);
    if (!next_st.status.loaded || next_st.status.powered_down) begin
      next_st.level = dswl_pkg::CODE_RESET;
    end else begin
      next_st.level = next_st.code;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign analog_level_out_o = st.level;
  assign power_mode_o = st.mode;
  assign powered_down_o = st.status.powered_down;
  assign loaded_o = st.status.loaded;
  assign frame_active_o = st.status.frame_active;
  assign update_o = st.status.update;
  assign abort_o = st.status.abort;

endmodule

// *** verilog/dswl_pkg.sv ***
/*
  dswl_pkg: shared constants, word layout, modes and carrier structs for
  the serial word loader of a 10-bit converter.
  Assumes: used by the loader and link capture files, not by dswl_sync2; nothing is imported.
*/
package dswl_pkg;

  // serial word geometry
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 10;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] LAST_EDGE_CNT = 5'h0f;
  localparam logic [4:0] FULL_CNT = 5'h10;

  // field positions inside the received word
  localparam int MODE_MSB = 13;
  localparam int MODE_LSB = 12;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 2;

  // reset values
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    DSWL_MODE_RUN = 2'b00,
    DSWL_MODE_PD_1K = 2'b01,
    DSWL_MODE_PD_100K = 2'b10,
    DSWL_MODE_PD_OPEN = 2'b11
  } dswl_mode_t;

  // serial pins seen by the device
  typedef struct packed {
    logic frame_n;
    logic din;
  } dswl_link_t;

  // status carried to the user side
  typedef struct packed {
    logic loaded;
    logic powered_down;
    logic frame_active;
    logic update;
    logic abort;
  } dswl_status_t;

endpackage

// *** verilog/dswl_sync2.sv ***
/*
  dswl_sync2: two flip-flop synchroniser for levels and toggles.
  Assumes: inputs come from another clock domain or from pins.
*/
`timescale 1ns/1ns
module dswl_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // crossing
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dswl_sync_state_t;

  dswl_sync_state_t st;
  dswl_sync_state_t next_st;

  always_comb begin
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st <= {RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule

// *** verilog/dswl_link_shift.sv ***
/*
  dswl_link_shift: link-side capture of one 16-bit serial word.
  Assumes: runs on the falling edge of the serial clock; frame_n high
  clears the bit counter without a clock; the held word and its toggle
  are read in the system domain only after the toggle is synchronised.
*/
`timescale 1ns/1ns
module dswl_link_shift (
  // link clock and pins
  input wire logic sclk_i,
  input wire dswl_pkg::dswl_link_t link_i,
  // system reset, used only to clear the held word and the toggle
  input wire logic resetn_i,
  // captured word
  output logic [dswl_pkg::WORD_BITS-1:0] word_o,
  output logic toggle_o
);

  typedef struct packed {
    logic [dswl_pkg::CNT_BITS-1:0] cnt;
    logic [dswl_pkg::WORD_BITS-1:0] shift;
  } dswl_frame_state_t;

  typedef struct packed {
    logic [dswl_pkg::WORD_BITS-1:0] hold;
    logic tgl;
  } dswl_hand_state_t;

  dswl_frame_state_t fr;
  dswl_frame_state_t next_fr;
  dswl_hand_state_t hs;
  dswl_hand_state_t next_hs;

  // shift only inside a frame, stop after the 16th edge
  always_comb begin
    next_fr = fr;
    if (fr.cnt < dswl_pkg::FULL_CNT) begin
      next_fr.shift = {fr.shift[dswl_pkg::WORD_BITS-2:0], link_i.din};
      next_fr.cnt = fr.cnt + 5'h01;
    end
  end

  // frame high holds the register disabled and drops partial words
  always_ff @(negedge sclk_i or posedge link_i.frame_n) begin
    if (link_i.frame_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // 16th falling edge hands the full word over
  always_comb begin
    next_hs = hs;
    if (fr.cnt == dswl_pkg::LAST_EDGE_CNT) begin
      next_hs.hold = {fr.shift[dswl_pkg::WORD_BITS-2:0], link_i.din};
      next_hs.tgl = ~hs.tgl;
    end
  end

  always_ff @(negedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hs <= '0;
    end else begin
      hs <= next_hs;
    end
  end

  assign word_o = hs.hold;
  assign toggle_o = hs.tgl;

endmodule

// *** testbench/dswl_loader_assertions.sv ***
/* dswl_loader_assertions: port checks of the loader.
   Assumes: bound to dswl_loader; system clock domain only. */
`timescale 1ns/1ns
module dswl_loader_assertions (
  // system
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // outputs
  input wire logic [9:0] analog_level_out_o,
  input wire logic [1:0] power_mode_o,
  input wire logic powered_down_o,
  input wire logic loaded_o,
  input wire logic update_o,
  input wire logic abort_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_upd;
    $rose(update_o);
  endsequence
  sequence s_quiet;
    !update_o && $stable(analog_level_out_o);
  endsequence
  chk_upd_pulse: assert property (s_upd |=> s_quiet [*2])
    else $error("update pulse too long");
  chk_level_hold: assert property (s_quiet or update_o)
    else $error("level moved without update");
  chk_mode_hold: assert property (!update_o |-> $stable(power_mode_o))
    else $error("mode moved without update");
  chk_abort_pulse: assert property (abort_o |-> !update_o ##1 !abort_o)
    else $error("bad abort pulse");
  chk_zero_unloaded: assert property (!loaded_o |-> !analog_level_out_o)
    else $error("level before first word");
  chk_loaded_sticky: assert property (loaded_o |=> loaded_o)
    else $error("loaded dropped");
  chk_upd_loads: assert property (update_o |=> loaded_o)
    else $error("update without loaded");
  chk_pd_zero: assert property (powered_down_o |-> !analog_level_out_o)
    else $error("level in power-down");
  chk_pd_mode: assert property (powered_down_o == (power_mode_o != 2'b00))
    else $error("power-down flag wrong");
endmodule

bind dswl_loader dswl_loader_assertions u_chk (.clk_sys_i, .resetn_i,
  .analog_level_out_o, .power_mode_o, .powered_down_o, .loaded_o,
  .update_o, .abort_o);

// *** testbench/dswl_host.sv ***
/* dswl_host: serial master model for the loader's link.
   Assumes: go_i rises once per frame; sclk idles high. */
`timescale 1ns/1ns
module dswl_host (
  // request
  input wire logic go_i,
  input wire logic [15:0] word_i,
  input wire logic [4:0] nbits_i,
  // link
  output logic sclk_o,
  output logic frame_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b1;
    frame_n_o = 1'b1;
    din_o = 1'b0;
    forever begin
      @(posedge go_i);
      #13 frame_n_o = 1'b0;
      for (int k = 0; k < nbits_i; k++) begin
        din_o = word_i[15-k];
        #40 sclk_o = 1'b0;
        #40 sclk_o = 1'b1;
      end
      #20 frame_n_o = 1'b1;
      din_o = ~din_o;
    end
  end
endmodule

// *** testbench/testbench.sv ***
/* testbench: drives the loader through the host model and scores
   update and abort pulses against notes in a queue.
   Assumes: 50 ns system clock, 80 ns serial bit time. */
`timescale 1ns/1ns
module testbench;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic go = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [4:0] nbits = 5'h00;
  logic sclk, frame_n, din, pd, loaded, act, upd, abt;
  logic [9:0] level;
  logic [1:0] mode;
  logic [12:0] q[$];
  logic [9:0] cur = 10'h000;
  logic [1:0] curm = 2'b00;
  logic [31:0] seed = 32'h08de;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  dswl_host host (.go_i(go), .word_i(word), .nbits_i(nbits),
    .sclk_o(sclk), .frame_n_o(frame_n), .din_o(din));
  dswl_loader dut (.clk_sys_i, .resetn_i, .sclk_i(sclk),
    .frame_n_i(frame_n), .din_i(din), .analog_level_out_o(level),
    .power_mode_o(mode), .powered_down_o(pd), .loaded_o(loaded),
    .frame_active_o(act), .update_o(upd), .abort_o(abt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic send(input logic [1:0] m, input logic [4:0] n);
    logic [31:0] r;
    r = rnd();
    @(negedge clk_sys_i);
    word = {r[15:14], m, r[11:0]};
    nbits = n;
    go = 1'b1;
    if (n == 5'h10) begin
      curm = m;
      cur = (m == 2'b00) ? r[11:2] : 10'h000;
    end
    q.push_back({n != 5'h10, curm, cur});
    @(negedge clk_sys_i);
    go = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check({15'h0000, act}, 16'h0001);
    repeat (38) @(negedge clk_sys_i);
  endtask
  always @(negedge clk_sys_i) begin
    if (upd === 1'b1 || abt === 1'b1) begin
      check({3'h0, abt, mode, level},
        {3'h0, (q.size() != 0) ? q.pop_front() : 13'h1fff});
    end
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check({2'h0, loaded, pd, level, mode}, 16'h0000);
    send(2'b00, 5'h0f);
    check({2'h0, loaded, pd, level, mode}, 16'h0000);
    $display("test early abort done");
    for (int i = 0; i < 8; i++) begin
      send(2'b00, 5'h10);
    end
    $display("test codes done");
    for (int m = 1; m < 4; m++) begin
      send(2'(m), 5'h10);
      send(2'b00, 5'h10);
    end
    $display("test power modes done");
    send(2'b00, 5'(1 + rnd() % 15));
    $display("test late abort done");
    @(negedge clk_sys_i);
    resetn_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check({2'h0, loaded, pd, level, mode}, 16'h0000);
    $display("test second reset done");
    check(16'(q.size()), 16'h0000);
    end_sim();
  end
endmodule
